// ==== design/lf_frontend_map.svh ====
// Register offsets, field positions, reset values and timing figures
// of the low-frequency front-end control block.
// Assumes a 32-bit APB slave, one register per aligned word.
`ifndef LF_FRONTEND_MAP_SVH
`define LF_FRONTEND_MAP_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define CFG_COUNT        8
`define CFG_WIDTH        9
`define PARITY_INDEX     6
`define STATUS_INDEX     7
`define CMD_INDEX        8
`define INDEX_LSB        2

// ----------------------------------------
// Fields (bit 0 of every configuration word is its row parity)
// ----------------------------------------
`define F_ROW_PARITY     0
`define F_OEH_HI         8
`define F_OEH_LO         7
`define F_OEL_HI         6
`define F_OEL_LO         5
`define F_OUT_SELECT     8
`define F_ENABLE_HI      7
`define F_ENABLE_LO      5
`define F_SENS_HI        8
`define F_SENS_LO        7
`define F_TUNE_HI        6
`define F_TUNE_LO        1
`define F_AUTO_SELECT    8
`define TUNE_REG_BASE    2
`define SENS_WIDTH       2
`define TUNE_WIDTH       6
`define CMD_CLAMP_ON     0
`define CMD_CLAMP_OFF    1
`define CMD_SOFT_RESET   2

// ----------------------------------------
// Reset values (odd row parity over all nine bits)
// ----------------------------------------
`define CFG_RESET_VALUE  9'h001
`define CFG1_RESET_VALUE 9'h0E0

// ----------------------------------------
// Timing
// ----------------------------------------
`define LINK_PERIOD_NS   125
`define INACT_TIMEOUT_NS 16000000
`define SETTLE_TIME_NS   3500000
`define CLAMP_PULSE_NS   2000

`endif

// ==== design/lf_frontend_pkg.sv ====
// Types shared by the front-end control design.
// Assumes the constants of lf_frontend_map.svh are included alongside.
package lf_frontend_pkg;

  typedef enum logic [3:0] {
    ST_STANDBY    = 4'b0001,
    ST_SETTLE     = 4'b0010,
    ST_ACTIVE     = 4'b0100,
    ST_SOFT_RESET = 4'b1000
  } link_state_t;

  typedef logic [8:0] cfg_word_t;

endpackage : lf_frontend_pkg

// ==== design/sync_two_flop.sv ====
// Two flip-flop level synchroniser, one per bit.
// Assumes each bit is an independent level or a toggle.
`timescale 1ns/1ns
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sync_two_flop

// ==== design/lf_frontend_digital_control.sv ====
// Digital control of a three-channel low-frequency receive front end:
// APB configuration registers, command crossing, gain settling, auto
// channel selection, inactivity soft reset and output selection.
// Assumes channel data, carrier clock and filter result arrive as pins
// sampled on link_clock; the wake-up filter itself is outside.
//
// Contract
// - Eight configuration registers: six options, one column parity, one status.
// - Each register is nine bits; the writer supplies the row parity bit.
// - All registers read and write except status, which ignores writes.
// - Clamp on/off commands switch the transistor only on enabled channels.
// - After any soft reset or inactivity expiry, clamp briefly then release.
// - Per-channel tuning capacitance field, 0 to 63 pF in 1 pF steps.
// - Per-channel sensitivity setting lowers receive sensitivity below optimum.
// - Auto channel selection on when register 5 bit 8 is one.
// - At end of settling, pass channels sampling high, block low ones.
// - Status bits 8 to 6 show selection outcome, refreshed at end of settling.
// - Soft reset or inactivity expiry clears selection; all channels pass again.
// - Blocking touches only demodulated data, not carrier clock or strength.
// - Output carries carrier clock when register 1 output select chooses it.
// - Sliced data of the three channels is ORed before the wake-up filter.
// - Data output stays disabled until the wake-up filter passes.
// - No input level change for about 16 ms causes a soft reset.
// - Settling lasts about 3.5 ms with filter in reset; low input at its end aborts.
`timescale 1ns/1ns
`include "lf_frontend_map.svh"
module lf_frontend_digital_control
  import lf_frontend_pkg::*;
#(
  parameter int CHANNELS      = 3,
  parameter int ADDR_WIDTH    = 12,
  parameter int INACT_CYCLES  = `INACT_TIMEOUT_NS / `LINK_PERIOD_NS,
  parameter int SETTLE_CYCLES = `SETTLE_TIME_NS / `LINK_PERIOD_NS
) (
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_WIDTH-1:0]           paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            link_clock,
  input  wire logic [CHANNELS-1:0]             channel_data,
  input  wire logic                            carrier_clock,
  input  wire logic                            filter_pass,
  output logic      [CHANNELS-1:0]             modulation_clamp,
  output logic      [CHANNELS*`TUNE_WIDTH-1:0] tuning_cap,
  output logic      [CHANNELS*`SENS_WIDTH-1:0] sensitivity,
  output logic      [1:0]                      filter_high_time,
  output logic      [1:0]                      filter_low_time,
  output logic                                 filter_data,
  output logic                                 filter_reset,
  output logic                                 lf_data_output,
  output logic                                 lf_data_enable
);

  localparam int CLAMP_CYCLES = (`CLAMP_PULSE_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS;
  localparam int CNT_W        = $clog2(INACT_CYCLES + SETTLE_CYCLES + 1);
  localparam int STAT_W       = 2 * CHANNELS + 1;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [ADDR_WIDTH-1:0] index;
  logic                  mapped;
  logic                  wr_hit;
  logic                  rd_setup;

  assign index  = paddr >> `INDEX_LSB;
  assign pready = 1'b1;

  always_comb begin
    if (paddr[`INDEX_LSB-1:0] != '0) begin
      mapped = 1'b0;
    end else if (index <= ADDR_WIDTH'(`CMD_INDEX)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr  = psel && penable && !mapped;
  assign wr_hit   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  cfg_word_t                cfg [`CFG_COUNT-1];
  logic                     cfg_dirty;
  logic                     parity_error;
  logic [STAT_W-1:0]        status_sync;
  cfg_word_t                status_word;

  genvar gi;
  generate
    for (gi = 0; gi < `CFG_COUNT - 1; gi++) begin : g_cfg
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cfg[gi] <= (gi == 1) ? `CFG1_RESET_VALUE : `CFG_RESET_VALUE;
        end else if (wr_hit && index == ADDR_WIDTH'(gi)) begin
          // Parity is stored as written, never recomputed
          cfg[gi] <= pwdata[`CFG_WIDTH-1:0];
        end
      end
    end
  endgenerate

  always_comb begin
    parity_error = 1'b0;
    for (int i = 0; i < `CFG_COUNT - 1; i++) begin
      if (!(^cfg[i])) begin
        parity_error = 1'b1;
      end
    end
  end

  // Status: selection, settling done, woken channels, parity error, parity
  always_comb begin
    status_word                 = '0;
    status_word[8:6]            = status_sync[2*CHANNELS:CHANNELS+1];
    status_word[5]              = status_sync[CHANNELS];
    status_word[4:2]            = status_sync[CHANNELS-1:0];
    status_word[1]              = parity_error;
    status_word[`F_ROW_PARITY]  = ~(^status_word[8:1]);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      if (index < ADDR_WIDTH'(`STATUS_INDEX) && paddr[`INDEX_LSB-1:0] == '0) begin
        prdata <= {23'h000000, cfg[index[2:0]]};
      end else if (index == ADDR_WIDTH'(`STATUS_INDEX) && paddr[`INDEX_LSB-1:0] == '0) begin
        prdata <= {23'h000000, status_word};
      end else begin
        prdata <= '0;
      end
    end
  end

  // ----------------------------------------
  // Configuration crossing (toggle handshake)
  // ----------------------------------------
  // The snapshot only changes once the link side has acknowledged the
  // previous one, so the link side never samples a word in motion.
  logic [`CFG_WIDTH*6-1:0] cfg_snapshot;
  logic                    cfg_req;
  logic                    cfg_ack_sync;
  logic [2:0]              cmd_toggle;
  logic                    cfg_write;

  assign cfg_write = wr_hit && index < ADDR_WIDTH'(`PARITY_INDEX);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_dirty    <= 1'b1;
      cfg_req      <= 1'b0;
      cfg_snapshot <= '0;
    end else if (cfg_dirty && cfg_req == cfg_ack_sync) begin
      cfg_snapshot <= {cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]};
      cfg_req      <= ~cfg_req;
      cfg_dirty    <= cfg_write;
    end else if (cfg_write) begin
      cfg_dirty <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_toggle <= '0;
    end else if (wr_hit && index == ADDR_WIDTH'(`CMD_INDEX)) begin
      cmd_toggle <= cmd_toggle ^ pwdata[2:0];
    end
  end

  // ----------------------------------------
  // Link-side and bus-side synchronisers
  // ----------------------------------------
  logic [CHANNELS-1:0] data_s;
  logic                carrier_s;
  logic                pass_s;
  logic [2:0]          cmd_s;
  logic                cfg_req_s;
  logic                cfg_ack;
  logic [STAT_W-1:0]   status_link;

  sync_two_flop #(.WIDTH(CHANNELS + 6)) u_link_sync (
    .clock (link_clock),
    .rst   (sys_rst),
    .d     ({channel_data, carrier_clock, filter_pass, cmd_toggle, cfg_req}),
    .q     ({data_s, carrier_s, pass_s, cmd_s, cfg_req_s})
  );

  sync_two_flop #(.WIDTH(STAT_W + 1)) u_bus_sync (
    .clock (clock),
    .rst   (sys_rst),
    .d     ({status_link, cfg_ack}),
    .q     ({status_sync, cfg_ack_sync})
  );

  // ----------------------------------------
  // Link-side configuration
  // ----------------------------------------
  logic [`CFG_WIDTH*6-1:0] link_cfg;
  logic [2:0]              cmd_seen;
  logic [2:0]              cmd_event;
  logic [CHANNELS-1:0]     enable;
  logic                    auto_channel_select_bit;
  logic                    output_source_select;

  assign cmd_event               = cmd_s ^ cmd_seen;
  assign enable                  = link_cfg[`CFG_WIDTH+`F_ENABLE_HI:`CFG_WIDTH+`F_ENABLE_LO];
  assign auto_channel_select_bit = link_cfg[`CFG_WIDTH*5+`F_AUTO_SELECT];
  assign output_source_select    = link_cfg[`CFG_WIDTH+`F_OUT_SELECT];
  assign filter_high_time        = link_cfg[`F_OEH_HI:`F_OEH_LO];
  assign filter_low_time         = link_cfg[`F_OEL_HI:`F_OEL_LO];

  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_cfg <= '0;
      cfg_ack  <= 1'b0;
      cmd_seen <= '0;
    end else begin
      cmd_seen <= cmd_s;
      if (cfg_req_s != cfg_ack) begin
        link_cfg <= cfg_snapshot;
        cfg_ack  <= cfg_req_s;
      end
    end
  end

  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      localparam int BASE = `CFG_WIDTH * (`TUNE_REG_BASE + gi);
      assign tuning_cap[gi*`TUNE_WIDTH +: `TUNE_WIDTH] =
        link_cfg[BASE+`F_TUNE_HI:BASE+`F_TUNE_LO];
      assign sensitivity[gi*`SENS_WIDTH +: `SENS_WIDTH] =
        link_cfg[BASE+`F_SENS_HI:BASE+`F_SENS_LO];
    end
  endgenerate

  // ----------------------------------------
  // Settling, inactivity and soft reset sequencer
  // ----------------------------------------
  link_state_t         state;
  logic [CNT_W-1:0]    count;
  logic [CHANNELS-1:0] selected;
  logic [CHANNELS-1:0] woken;
  logic                any_signal;
  logic                prev_signal;

  assign any_signal  = |(data_s & enable);
  assign status_link = {selected, state == ST_ACTIVE, woken};

  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= ST_STANDBY;
      count       <= '0;
      selected    <= '1;
      woken       <= '0;
      prev_signal <= 1'b0;
    end else begin
      prev_signal <= any_signal;
      if (cmd_event[`CMD_SOFT_RESET]) begin
        state <= ST_SOFT_RESET;
        count <= '0;
      end else begin
        case (state)
          ST_STANDBY: begin
            count <= '0;
            if (any_signal) begin
              state <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            // Filter held in reset for the whole settling window
            if (count == CNT_W'(SETTLE_CYCLES - 1)) begin
              count <= '0;
              if (any_signal) begin
                state <= ST_ACTIVE;
                woken <= data_s & enable;
                if (auto_channel_select_bit) begin
                  selected <= data_s;
                end
              end else begin
                state <= ST_SOFT_RESET;
              end
            end else begin
              count <= count + CNT_W'(1);
            end
          end
          ST_ACTIVE: begin
            // A change of the ORed level of the enabled channels, or any bus command, restarts the timeout
            if (any_signal != prev_signal || cmd_event != '0) begin
              count <= '0;
            end else if (count == CNT_W'(INACT_CYCLES - 1)) begin
              state <= ST_SOFT_RESET;
              count <= '0;
            end else begin
              count <= count + CNT_W'(1);
            end
          end
          ST_SOFT_RESET: begin
            selected <= '1;
            if (count == CNT_W'(CLAMP_CYCLES - 1)) begin
              state <= ST_STANDBY;
              count <= '0;
            end else begin
              count <= count + CNT_W'(1);
            end
          end
          default: begin
            state <= ST_STANDBY;
            count <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Modulation transistor
  // ----------------------------------------
  // Commands are the talk-back symbols; off wins if both arrive together.
  logic [CHANNELS-1:0] clamp_state;

  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      clamp_state <= '0;
    end else if (cmd_event[`CMD_CLAMP_OFF]) begin
      clamp_state <= clamp_state & ~enable;
    end else if (cmd_event[`CMD_CLAMP_ON]) begin
      clamp_state <= clamp_state | enable;
    end
  end

  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      modulation_clamp <= '0;
    end else if (state == ST_SOFT_RESET) begin
      modulation_clamp <= enable;
    end else begin
      modulation_clamp <= clamp_state;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  logic combined;

  assign combined     = |(data_s & enable & selected);
  assign filter_reset = state != ST_ACTIVE;

  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      filter_data    <= 1'b0;
      lf_data_output <= 1'b0;
      lf_data_enable <= 1'b0;
    end else begin
      filter_data    <= combined;
      lf_data_enable <= pass_s && state == ST_ACTIVE;
      if (!(pass_s && state == ST_ACTIVE)) begin
        lf_data_output <= 1'b0;
      end else if (output_source_select) begin
        lf_data_output <= carrier_s;
      end else begin
        lf_data_output <= combined;
      end
    end
  end

endmodule : lf_frontend_digital_control

// ==== tb/lf_frontend_digital_control_asserts.sv ====
// Port-level checks of the front-end control block.
// Assumes it is bound into lf_frontend_digital_control; sys_rst resets both domains.
`timescale 1ns/1ns
module lf_frontend_digital_control_asserts #(
  parameter int CHANNELS   = 3,
  parameter int ADDR_WIDTH = 12
) (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  link_clock,
  input wire logic [CHANNELS-1:0]   channel_data,
  input wire logic [CHANNELS-1:0]   modulation_clamp,
  input wire logic                  filter_data,
  input wire logic                  filter_reset,
  input wire logic                  lf_data_output,
  input wire logic                  lf_data_enable
);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_err_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
    psel && penable && (paddr[1:0] != 2'h0 || paddr[ADDR_WIDTH-1:2] > 8) |-> pslverr)
    else $error("unmapped access gave no error");
  a_err_access: assert property (@(posedge clock) disable iff (sys_rst)
    pslverr |-> psel && penable) else $error("error outside access phase");
  a_upper_zero: assert property (@(posedge clock) disable iff (sys_rst)
    prdata[31:9] == 23'h0) else $error("read data above bit 8 not zero");
  a_read_holds: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  // ----------------------------------------
  // Link side
  // ----------------------------------------
  a_or_feed: assert property (@(posedge link_clock) disable iff (sys_rst)
    filter_data |-> $past(|channel_data, 2) || $past(|channel_data, 3)
      || $past(|channel_data, 4)) else $error("filter data without any channel high");
  a_enable_active: assert property (@(posedge link_clock) disable iff (sys_rst)
    $rose(lf_data_enable) |-> !filter_reset) else $error("output enabled while filter held");
  a_quiet_off: assert property (@(posedge link_clock) disable iff (sys_rst)
    !lf_data_enable && !$past(lf_data_enable) |-> !lf_data_output)
    else $error("output driven while disabled");
  a_filter_held: assert property (@(posedge link_clock) disable iff (sys_rst)
    filter_reset [*3] |-> !lf_data_enable) else $error("output enabled during settling");
  c_wake: cover property (@(posedge link_clock) disable iff (sys_rst) $rose(lf_data_enable));
  c_settled: cover property (@(posedge link_clock) disable iff (sys_rst) $fell(filter_reset));
  c_clamp_all: cover property (@(posedge link_clock) disable iff (sys_rst)
    $rose(&modulation_clamp));
endmodule : lf_frontend_digital_control_asserts

// ==== tb/lf_signal_source.sv ====
// Behavioural stand-in for the receive channels, carrier detector and wake-up filter.
// Assumes the bench steers it through level controls; it moves only on link_clock.
`timescale 1ns/1ns
module lf_signal_source (
  input  wire logic       link_clock,
  input  wire logic       sys_rst,
  input  wire logic       burst,
  input  wire logic [2:0] level_mask,
  input  wire logic       wake,
  output logic      [2:0] channel_data,
  output logic            carrier_clock,
  output logic            filter_pass
);
  // ----------------------------------------
  // Field seen at the antennas
  // ----------------------------------------
  always_ff @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      channel_data  <= 3'h0;
      carrier_clock <= 1'b0;
      filter_pass   <= 1'b0;
    end else begin
      channel_data  <= burst ? level_mask : 3'h0;
      // Carrier stands still between bursts, as a real detector would
      carrier_clock <= burst && !carrier_clock;
      filter_pass   <= burst && wake;
    end
  end
endmodule : lf_signal_source

// ==== tb/lf_frontend_digital_control_tb.sv ====
// Self-checking bench: register table, clamp commands, auto selection, soft reset.
// Assumes the design, lf_signal_source and the checker are compiled before it.
`timescale 1ns/1ns
`define CHECK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module lf_frontend_digital_control_tb;
  localparam int INACT  = 100;
  localparam int SETTLE = 20;
  typedef struct packed {logic [11:0] a; logic [8:0] w; logic [8:0] x; logic e;} row_t;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, link_clock;
  logic        carrier_clock, filter_pass, filter_data, filter_reset;
  logic        lf_data_output, lf_data_enable, burst, wake, err, seen0, seen1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [2:0]  channel_data, modulation_clamp, level_mask;
  logic [17:0] tuning_cap;
  logic [5:0]  sensitivity;
  logic [1:0]  filter_high_time, filter_low_time;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n;
  row_t rows [9] = '{
    '{12'h000, 9'h1C0, 9'h1C0, 1'b0}, '{12'h004, 9'h0E0, 9'h0E0, 1'b0},
    '{12'h008, 9'h07F, 9'h07F, 1'b0}, '{12'h00C, 9'h181, 9'h181, 1'b0},
    '{12'h010, 9'h002, 9'h002, 1'b0}, '{12'h014, 9'h001, 9'h001, 1'b0},
    '{12'h018, 9'h155, 9'h155, 1'b0}, '{12'h024, 9'h1FF, 9'h000, 1'b1},
    '{12'h002, 9'h1FF, 9'h000, 1'b1}};

  lf_frontend_digital_control #(.INACT_CYCLES(INACT), .SETTLE_CYCLES(SETTLE)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clock(link_clock), .channel_data(channel_data), .carrier_clock(carrier_clock),
    .filter_pass(filter_pass), .modulation_clamp(modulation_clamp),
    .tuning_cap(tuning_cap), .sensitivity(sensitivity), .filter_high_time(filter_high_time),
    .filter_low_time(filter_low_time), .filter_data(filter_data),
    .filter_reset(filter_reset), .lf_data_output(lf_data_output),
    .lf_data_enable(lf_data_enable));
  lf_signal_source u_src (.link_clock(link_clock), .sys_rst(sys_rst), .burst(burst),
    .level_mask(level_mask), .wake(wake), .channel_data(channel_data),
    .carrier_clock(carrier_clock), .filter_pass(filter_pass));

  // ----------------------------------------
  // Clocks, bus tasks and verdict
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #17;
    forever begin
      #62 link_clock = 1'b1;
      #63 link_clock = 1'b0;
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic lwait(input int k);
    repeat (k) @(posedge link_clock);
  endtask : lwait
  task automatic hard_reset;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : hard_reset
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Whole run is some 40 us; a hang is cut well after that
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {burst, wake, level_mask} = '0;
    sys_rst = 1'b1;
    hard_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, {23'h0, rows[i].w}, rd, err);
      `CHECK("write error", rows[i].e, err)
      apb(1'b0, rows[i].a, 32'h0, rd, err);
      `CHECK("read back", {23'h0, rows[i].x}, rd)
      `CHECK("read error", rows[i].e, err)
    end
    lwait(12);
    `CHECK("tune ch0", 6'h3F, tuning_cap[5:0])
    `CHECK("tune ch2", 6'h01, tuning_cap[17:12])
    `CHECK("sens ch1", 2'h3, sensitivity[3:2])
    `CHECK("filter high", 2'h3, filter_high_time)
    `CHECK("filter low", 2'h2, filter_low_time)
    `CHECK("ready", 1'b1, pready)
    apb(1'b0, 12'h01C, 32'h0, st, err);
    apb(1'b1, 12'h01C, 32'h1FF, rd, err);
    apb(1'b0, 12'h01C, 32'h0, rd, err);
    `CHECK("status kept", st, rd)
    // Talk-back symbol with channel 1 disabled
    apb(1'b1, 12'h004, 32'h0A1, rd, err);
    lwait(10);
    apb(1'b1, 12'h020, 32'h1, rd, err);
    lwait(12);
    `CHECK("clamp on", 3'b101, modulation_clamp)
    apb(1'b1, 12'h020, 32'h2, rd, err);
    lwait(12);
    `CHECK("clamp off", 3'b000, modulation_clamp)
    apb(1'b1, 12'h004, 32'h0E0, rd, err);
    apb(1'b1, 12'h014, 32'h100, rd, err);
    lwait(10);
    level_mask <= 3'b001;
    burst      <= 1'b1;
    n = 0;
    while (filter_reset !== 1'b0 && n < 200) begin
      @(posedge link_clock);
      n++;
    end
    `CHECK("settle span", 1'b1, n >= SETTLE && n <= SETTLE + 10)
    lwait(4);
    `CHECK("held off", 1'b0, lf_data_enable)
    `CHECK("ored data", 1'b1, filter_data)
    apb(1'b0, 12'h01C, 32'h0, rd, err);
    `CHECK("selection", 8'h32, rd[8:1])
    wake <= 1'b1;
    lwait(8);
    `CHECK("woken", 1'b1, lf_data_enable)
    `CHECK("data out", 1'b1, lf_data_output)
    level_mask <= 3'b010;
    lwait(6);
    `CHECK("blocked", 1'b0, filter_data)
    apb(1'b1, 12'h004, 32'h1E1, rd, err);
    {seen0, seen1} = 2'b00;
    repeat (30) begin
      @(posedge link_clock);
      seen0 = seen0 | (lf_data_output === 1'b0);
      seen1 = seen1 | (lf_data_output === 1'b1);
    end
    `CHECK("carrier out", 2'b11, {seen0, seen1})
    burst <= 1'b0;
    n = 0;
    while (modulation_clamp !== 3'b111 && n < 300) begin
      @(posedge link_clock);
      n++;
    end
    `CHECK("inactivity", 1'b1, n >= INACT && n <= INACT + 12)
    n = 0;
    while (modulation_clamp === 3'b111 && n < 40) begin
      @(posedge link_clock);
      n++;
    end
    `CHECK("reset clamp", 1'b1, n >= 15 && n <= 17)
    apb(1'b0, 12'h01C, 32'h0, rd, err);
    `CHECK("sel cleared", 3'b111, rd[8:6])
    // Soft reset by command must also pulse the clamp on enabled channels
    apb(1'b1, 12'h020, 32'h4, rd, err);
    n = 0;
    while (modulation_clamp !== 3'b111 && n < 20) begin
      @(posedge link_clock);
      n++;
    end
    `CHECK("reset cmd clamp", 1'b1, n < 20)
    hard_reset();
    apb(1'b0, 12'h004, 32'h0, rd, err);
    `CHECK("reg1 reset", 32'h0E0, rd)
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHECK("reg0 reset", 32'h001, rd)
    `CHECK("clamp reset", 3'b000, modulation_clamp)
    tally_and_finish();
  end
endmodule : lf_frontend_digital_control_tb

bind lf_frontend_digital_control lf_frontend_digital_control_asserts #(
  .CHANNELS(CHANNELS), .ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .link_clock(link_clock),
  .channel_data(channel_data), .modulation_clamp(modulation_clamp),
  .filter_data(filter_data), .filter_reset(filter_reset),
  .lf_data_output(lf_data_output), .lf_data_enable(lf_data_enable));
